// ### rtl/pst_latch_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pst_latch_mem (
   // Clock
   input  wire logic                          clock,
   // Write side, one enable per byte lane
   input  wire logic [2:0]                    write_lane,
   input  wire logic [pst_pkg::LATCH_AW-1:0]  write_index,
   input  wire logic [pst_pkg::PWORD_W-1:0]   write_word,
   // Read side, data registered
   input  wire logic                          read_en,
   input  wire logic [pst_pkg::LATCH_AW-1:0]  read_index,
   output logic      [pst_pkg::PWORD_W-1:0]   read_word
);
   import pst_pkg::*;

   logic [PWORD_W-1:0] mem_reg [LATCH_DEPTH];

   // One process owns the whole array, so no lane has a second driver
   always_ff @(posedge clock) begin
      for (int lane = 0; lane < 3; lane++) begin
         if (write_lane[lane]) begin
            mem_reg[write_index][lane*8 +: 8] <= write_word[lane*8 +: 8];
         end
      end
      if (read_en) begin
         read_word <= mem_reg[read_index];
      end
   end
endmodule // pst_latch_mem
`default_nettype wire

// ### rtl/pst_pkg.sv
package pst_pkg;

   localparam int PADDR_W = 24;
   localparam int PWORD_W = 24;
   localparam int DWORD_W = 16;
   localparam int PAGE_W  = 8;
   localparam int EA_W    = 16;
   localparam int BUS_AW  = 8;

   localparam int CFG_BIT = 7;

   localparam logic [PAGE_W-1:0] PAGE_RESET  = 8'h00;
   localparam logic [PAGE_W-1:0] LATCH_PAGE  = 8'hFA;
   localparam int                LATCH_DEPTH = 64;
   localparam int                LATCH_AW    = 6;

   localparam logic [BUS_AW-1:0] REG_TABLE_PAGE  = 8'h00;
   localparam logic [BUS_AW-1:0] REG_REMAP_PAGE  = 8'h04;
   localparam logic [BUS_AW-1:0] REG_PROG_ADDR_L = 8'h08;
   localparam logic [BUS_AW-1:0] REG_PROG_ADDR_H = 8'h0C;
   localparam logic [BUS_AW-1:0] REG_PROG_CMD    = 8'h10;
   localparam logic [BUS_AW-1:0] REG_STATUS      = 8'h14;

   localparam int STAT_BUSY    = 0;
   localparam int STAT_REFUSED = 1;

   localparam logic [PADDR_W-1:0] FETCH_STEP = 24'h000002;

   localparam logic [9:0] DOUBLE_WORDS = 10'h002;
   localparam logic [9:0] ROW_WORDS    = 10'h040;
   localparam logic [9:0] ERASE_WORDS  = 10'h200;

   localparam logic [PADDR_W-1:0] DOUBLE_SPAN = {13'h0000, DOUBLE_WORDS, 1'b0};
   localparam logic [PADDR_W-1:0] ROW_SPAN    = {13'h0000, ROW_WORDS, 1'b0};
   localparam logic [PADDR_W-1:0] ERASE_SPAN  = {13'h0000, ERASE_WORDS, 1'b0};

   typedef enum logic [1:0] {
      TBL_READ_LOW   = 2'h0,
      TBL_READ_HIGH  = 2'h1,
      TBL_WRITE_LOW  = 2'h2,
      TBL_WRITE_HIGH = 2'h3
   } pst_table_op_type;

   typedef enum logic [1:0] {
      PROG_DOUBLE = 2'h0,
      PROG_ROW    = 2'h1,
      PROG_ERASE  = 2'h2
   } pst_prog_kind_type;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_ACCESS = 2'h1
   } pst_state_type;

   typedef struct packed {
      pst_table_op_type     op;
      logic                 byte_mode;
      logic [EA_W-1:0]      effective_address;
      logic [DWORD_W-1:0]   wdata;
   } pst_table_req_type;

   typedef struct packed {
      pst_prog_kind_type    kind;
      logic [PADDR_W-1:0]   base;
      logic [9:0]           words;
   } pst_prog_cmd_type;

   function automatic logic [PADDR_W-1:0] pst_span(input pst_prog_kind_type kind);
      case (kind)
         PROG_DOUBLE: pst_span = DOUBLE_SPAN;
         PROG_ROW:    pst_span = ROW_SPAN;
         default:     pst_span = ERASE_SPAN;
      endcase
   endfunction

   function automatic logic [9:0] pst_words(input pst_prog_kind_type kind);
      case (kind)
         PROG_DOUBLE: pst_words = DOUBLE_WORDS;
         PROG_ROW:    pst_words = ROW_WORDS;
         default:     pst_words = ERASE_WORDS;
      endcase
   endfunction

endpackage

// ### rtl/pst_prog_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pst_prog_unit (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         reset,
   // Start request
   input  wire logic                         start,
   input  wire logic [1:0]                   kind,
   input  wire logic [pst_pkg::PADDR_W-1:0]  target,
   // Command to the array controller
   output logic                              cmd_valid,
   output pst_pkg::pst_prog_cmd_type         cmd
);
   import pst_pkg::*;

   pst_prog_kind_type  kind_sel;
   logic               kind_ok;
   logic [PADDR_W-1:0] span;
   logic [PADDR_W-1:0] aligned;

   assign kind_sel = pst_prog_kind_type'(kind);
   assign kind_ok  = (kind_sel == PROG_DOUBLE) || (kind_sel == PROG_ROW)
                     || (kind_sel == PROG_ERASE);
   assign span     = pst_span(kind_sel);
   // Rows and pages are edge aligned from the start of program memory
   assign aligned  = target & ~(span - 24'h000001);

   always_ff @(posedge clock) begin
      if (reset) begin
         cmd_valid <= 1'b0;
         cmd       <= '0;
      end else begin
         cmd_valid <= start && kind_ok;
         if (start && kind_ok) begin
            cmd.kind  <= kind_sel;
            cmd.base  <= aligned;
            cmd.words <= pst_words(kind_sel);
         end
      end
   end

   a_prog_span_align: assert property (@(posedge clock) disable iff (reset)
      start && kind_ok |=> cmd_valid
      && ((cmd.base & (pst_span(cmd.kind) - 24'h000001)) == 24'h000000)
      && cmd.words == pst_words(cmd.kind))
      else $error("programming command misaligned or wrong size");
endmodule // pst_prog_unit
`default_nettype wire

// ### rtl/pst_table_access.sv
`timescale 1ns/1ps
`default_nettype none
module pst_table_access (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset,
   // Register port
   input  wire logic [pst_pkg::BUS_AW-1:0]    reg_addr,
   input  wire logic [pst_pkg::DWORD_W-1:0]   reg_wdata,
   input  wire logic                          reg_write,
   input  wire logic                          reg_read,
   output logic      [pst_pkg::DWORD_W-1:0]   reg_rdata,
   // Table operations from the core
   input  wire logic                          table_valid,
   input  wire pst_pkg::pst_table_req_type    table_req,
   output logic                               table_busy,
   output logic      [pst_pkg::DWORD_W-1:0]   table_rdata,
   output logic                               table_done,
   // Remapped read window
   input  wire logic                          remap_valid,
   input  wire logic [pst_pkg::EA_W-1:0]      remap_addr,
   output logic      [pst_pkg::DWORD_W-1:0]   remap_rdata,
   output logic                               remap_done,
   // Instruction fetch address
   input  wire logic                          fetch_load,
   input  wire logic [pst_pkg::PADDR_W-1:0]   fetch_target,
   input  wire logic                          fetch_step,
   output logic      [pst_pkg::PADDR_W-1:0]   fetch_addr,
   // Program array read port
   output logic                               flash_read,
   output logic      [pst_pkg::PADDR_W-1:0]   flash_addr,
   input  wire logic [pst_pkg::PWORD_W-1:0]   flash_rdata,
   // Programming command to the array controller
   output logic                               prog_valid,
   output pst_pkg::pst_prog_cmd_type          prog_cmd
);
   import pst_pkg::*;

   pst_state_type      state_reg;
   pst_state_type      state_next;
   pst_table_req_type  op_reg;
   logic               src_latch_reg;
   logic               remap_op_reg;
   logic [PAGE_W-1:0]  page_reg;
   logic [PAGE_W-1:0]  remap_page_reg;
   logic [PADDR_W-1:0] prog_addr_reg;
   logic               refused_reg;
   logic [PWORD_W-1:0] latch_word;

   // Formats a 24-bit program word for the data bus
   function automatic logic [DWORD_W-1:0] pst_format(input logic [PWORD_W-1:0] word,
                                                     input logic high, input logic byte_mode,
                                                     input logic byte_sel);
      logic [DWORD_W-1:0] result;
      result = 16'h0000;
      if (high) begin
         if (!byte_mode || !byte_sel) begin
            result = {8'h00, word[23:16]};
         end
      end else if (!byte_mode) begin
         result = word[15:0];
      end else begin
         result = {8'h00, byte_sel ? word[15:8] : word[7:0]};
      end
      return result;
   endfunction

   // Request decode
   wire                is_idle      = (state_reg == ST_IDLE);
   wire                take_table   = table_valid && is_idle;
   wire                take_remap   = remap_valid && !table_valid && is_idle;
   wire                is_write     = (table_req.op == TBL_WRITE_LOW)
                                      || (table_req.op == TBL_WRITE_HIGH);
   wire                byte_sel     = table_req.effective_address[0];
   wire [PADDR_W-1:0]  table_target = {page_reg, table_req.effective_address};
   wire                target_cfg   = page_reg[CFG_BIT];
   wire                target_latch = target_cfg && (page_reg == LATCH_PAGE);
   wire [PADDR_W-1:0]  remap_target = {remap_page_reg, remap_addr};

   // Write latch lanes: low ops own bits 15..0, high ops bits 23..16 only
   wire                write_low    = table_req.op == TBL_WRITE_LOW;
   wire                write_high   = table_req.op == TBL_WRITE_HIGH;
   wire                latch_we     = take_table && is_write && target_latch;
   wire [2:0]          lane_en      = {write_high && (!table_req.byte_mode || !byte_sel),
                                       write_low && (!table_req.byte_mode || byte_sel),
                                       write_low && (!table_req.byte_mode || !byte_sel)};
   wire [2:0]          write_lane   = latch_we ? lane_en : 3'h0;
   wire [PWORD_W-1:0]  write_word   = {table_req.wdata[7:0],
                                       table_req.byte_mode ? table_req.wdata[7:0]
                                                           : table_req.wdata[15:8],
                                       table_req.wdata[7:0]};
   wire                write_refuse = take_table && is_write && !target_latch;

   // Result path
   wire [PWORD_W-1:0]  src_word     = src_latch_reg ? latch_word : flash_rdata;
   wire                op_high      = (op_reg.op == TBL_READ_HIGH);
   wire                op_read      = (op_reg.op == TBL_READ_LOW) || op_high;
   wire [DWORD_W-1:0]  formatted    = pst_format(src_word, op_high, op_reg.byte_mode,
                                                 op_reg.effective_address[0]);
   wire [DWORD_W-1:0]  flash_low    = flash_rdata[15:0];
   wire [7:0]          flash_b0     = flash_rdata[7:0];
   wire [7:0]          flash_b1     = flash_rdata[15:8];
   wire [7:0]          flash_top    = flash_rdata[23:16];

   // Register port decode
   wire                wr_page      = reg_write && (reg_addr == REG_TABLE_PAGE);
   wire                wr_remap     = reg_write && (reg_addr == REG_REMAP_PAGE);
   wire                wr_prog_l    = reg_write && (reg_addr == REG_PROG_ADDR_L);
   wire                wr_prog_h    = reg_write && (reg_addr == REG_PROG_ADDR_H);
   wire                wr_prog_cmd  = reg_write && (reg_addr == REG_PROG_CMD);
   wire                clr_refused  = reg_write && (reg_addr == REG_STATUS)
                                      && reg_wdata[STAT_REFUSED];
   wire [PAGE_W-1:0]   wdata_low8   = reg_wdata[7:0];
   wire [DWORD_W-1:0]  status_word  = {14'h0000, refused_reg, state_reg == ST_ACCESS};
   wire [DWORD_W-1:0]  read_mux     =
      (reg_addr == REG_TABLE_PAGE)  ? {8'h00, page_reg} :
      (reg_addr == REG_REMAP_PAGE)  ? {8'h00, remap_page_reg} :
      (reg_addr == REG_PROG_ADDR_L) ? prog_addr_reg[15:0] :
      (reg_addr == REG_PROG_ADDR_H) ? {8'h00, prog_addr_reg[23:16]} :
      (reg_addr == REG_STATUS)      ? status_word : 16'h0000;

   // Fetch address: a load clears bit 23 and bit 0, a step keeps bit 0 clear but can carry into bit 23
   wire [PADDR_W-1:0]  fetch_even   = {1'b0, fetch_target[22:1], 1'b0};
   wire [PADDR_W-1:0]  fetch_inc    = fetch_addr + FETCH_STEP;

   assign state_next = (is_idle && (take_table || take_remap)) ? ST_ACCESS : ST_IDLE;

   pst_latch_mem u_latch (
      .clock       (clock),
      .write_lane  (write_lane),
      .write_index (table_req.effective_address[LATCH_AW:1]),
      .write_word  (write_word),
      .read_en     (take_table),
      .read_index  (table_req.effective_address[LATCH_AW:1]),
      .read_word   (latch_word)
   );

   pst_prog_unit u_prog (
      .clock     (clock),
      .reset     (reset),
      .start     (wr_prog_cmd),
      .kind      (reg_wdata[1:0]),
      .target    (prog_addr_reg),
      .cmd_valid (prog_valid),
      .cmd       (prog_cmd)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE:   state_reg <= state_next;
            ST_ACCESS: state_reg <= ST_IDLE;
            default:   state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         op_reg        <= '0;
         src_latch_reg <= 1'b0;
         remap_op_reg  <= 1'b0;
         flash_read    <= 1'b0;
         flash_addr    <= '0;
         table_busy    <= 1'b0;
      end else begin
         flash_read <= take_remap || (take_table && !is_write && !target_latch);
         table_busy <= take_table || take_remap;
         if (take_table) begin
            op_reg        <= table_req;
            src_latch_reg <= target_latch;
            remap_op_reg  <= 1'b0;
            flash_addr    <= table_target;
         end else if (take_remap) begin
            remap_op_reg  <= 1'b1;
            flash_addr    <= remap_target;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         table_done  <= 1'b0;
         table_rdata <= '0;
         remap_done  <= 1'b0;
         remap_rdata <= '0;
      end else begin
         table_done <= (state_reg == ST_ACCESS) && !remap_op_reg;
         remap_done <= (state_reg == ST_ACCESS) && remap_op_reg;
         if ((state_reg == ST_ACCESS) && !remap_op_reg && op_read) begin
            table_rdata <= formatted;
         end
         if ((state_reg == ST_ACCESS) && remap_op_reg) begin
            remap_rdata <= flash_low;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         page_reg       <= PAGE_RESET;
         remap_page_reg <= PAGE_RESET;
         prog_addr_reg  <= '0;
         refused_reg    <= 1'b0;
         reg_rdata      <= '0;
      end else begin
         if (wr_page) page_reg <= wdata_low8;
         if (wr_remap) remap_page_reg <= wdata_low8;
         if (wr_prog_l) prog_addr_reg[15:0] <= reg_wdata;
         if (wr_prog_h) prog_addr_reg[23:16] <= wdata_low8;
         // Hardware set wins over a software clear in the same cycle
         refused_reg <= write_refuse || (refused_reg && !clr_refused);
         reg_rdata   <= reg_read ? read_mux : 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         fetch_addr <= '0;
      end else if (fetch_load) begin
         fetch_addr <= fetch_even;
      end else if (fetch_step) begin
         fetch_addr <= fetch_inc;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_table_read_taken;
      take_table && !is_write && !target_latch;
   endsequence

   sequence s_flash_done_low_word;
      table_done && op_reg.op == TBL_READ_LOW && !src_latch_reg;
   endsequence

   a_target_address: assert property (s_table_read_taken |=> flash_read
      && flash_addr == $past(table_target)) else $error("table target address wrong");
   a_space_select: assert property (s_table_read_taken |=>
      flash_addr[EA_W+CFG_BIT] == $past(target_cfg)) else $error("space select bit wrong");
   a_fetch_load_even: assert property (fetch_load |=> fetch_addr == $past(fetch_even)
      && !fetch_addr[0]) else $error("fetch address not word aligned");
   a_fetch_step_two: assert property (fetch_step && !fetch_load |=>
      fetch_addr == $past(fetch_inc)) else $error("fetch step not two");
   a_low_word_read: assert property (s_table_read_taken ##1 1'b1 ##1
      (s_flash_done_low_word and !op_reg.byte_mode) |-> table_rdata == $past(flash_low))
      else $error("low word read altered data");
   a_low_byte_read: assert property (s_table_read_taken ##1 1'b1 ##1
      (s_flash_done_low_word and op_reg.byte_mode) |-> table_rdata == {8'h00,
      op_reg.effective_address[0] ? $past(flash_b1) : $past(flash_b0)})
      else $error("low byte select wrong");
   a_high_word_read: assert property (table_done && op_high && !op_reg.byte_mode
      && !src_latch_reg |-> table_rdata == {8'h00, $past(flash_top)})
      else $error("high word read wrong");
   a_phantom_zero: assert property (table_done && op_high && op_reg.byte_mode
      && op_reg.effective_address[0] |-> table_rdata == 16'h0000)
      else $error("phantom byte not zero");
   a_remap_low_word: assert property (take_remap |-> ##2 remap_done
      && remap_rdata == $past(flash_low)) else $error("remap read wrong");
   a_latch_only_write: assert property (write_lane != 3'h0 |-> take_table && is_write
      && target_latch) else $error("write outside write latches");
   a_write_no_array: assert property (take_table && is_write |=> !flash_read)
      else $error("table write reached the array");
   a_page_update: assert property (wr_page |=> page_reg == $past(wdata_low8))
      else $error("table page not updated");
endmodule // pst_table_access
`default_nettype wire

// ### test/pst_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pst_flash_model (
   // Clock
   input  wire logic                         clock,
   // Array read port
   input  wire logic                         flash_read,
   input  wire logic [pst_pkg::PADDR_W-1:0]  flash_addr,
   output logic      [pst_pkg::PWORD_W-1:0]  flash_rdata
);
   import pst_pkg::*;
   logic [PWORD_W-1:0] last_reg;
   // Outside a read cycle the bus shows the inverse of the last word, never a stale copy
   always_comb flash_rdata = flash_read ? (flash_addr ^ 24'hA5C33C) : ~last_reg;
   always_ff @(posedge clock) begin
      if (flash_read) begin
         last_reg <= flash_rdata;
      end
   end
endmodule // pst_flash_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pst_pkg::*;
   logic                 clock, reset, reg_write, reg_read, table_valid, table_busy;
   logic                 table_done, remap_valid, remap_done, fetch_load, fetch_step;
   logic                 flash_read, prog_valid;
   logic [BUS_AW-1:0]    reg_addr;
   logic [DWORD_W-1:0]   reg_wdata, reg_rdata, table_rdata, remap_rdata;
   logic [EA_W-1:0]      remap_addr;
   logic [PADDR_W-1:0]   fetch_target, fetch_addr, flash_addr;
   logic [PWORD_W-1:0]   flash_rdata;
   logic [PAGE_W-1:0]    cur_page;
   pst_table_req_type    table_req;
   pst_prog_cmd_type     prog_cmd;
   int                   fails, n_checks;

   pst_table_access pst_table_access_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .table_valid(table_valid), .table_req(table_req),
      .table_busy(table_busy), .table_rdata(table_rdata), .table_done(table_done),
      .remap_valid(remap_valid), .remap_addr(remap_addr), .remap_rdata(remap_rdata),
      .remap_done(remap_done), .fetch_load(fetch_load), .fetch_target(fetch_target),
      .fetch_step(fetch_step), .fetch_addr(fetch_addr), .flash_read(flash_read),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .prog_valid(prog_valid),
      .prog_cmd(prog_cmd));
   pst_flash_model pst_flash_model_inst (.clock(clock), .flash_read(flash_read),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // One table operation: raised after one edge, taken at the next, done at the edge after that
   task automatic tbl(input pst_table_op_type op, input logic bm, input logic [15:0] ea,
                      input logic [15:0] wd, input logic [15:0] exp);
      logic is_rd;
      logic from_array;
      is_rd = (op == TBL_READ_LOW) || (op == TBL_READ_HIGH);
      from_array = is_rd && (cur_page != LATCH_PAGE);
      @(posedge clock);
      table_valid <= 1'b1;
      table_req <= '{op: op, byte_mode: bm, effective_address: ea, wdata: wd};
      @(posedge clock);
      table_valid <= 1'b0;
      #1 chk(table_busy, 1'b1);
      chk(flash_read, from_array);
      if (from_array) chk(flash_addr, {cur_page, ea});
      @(posedge clock);
      #1 chk(table_done, 1'b1);
      if (is_rd) chk(table_rdata, exp);
   endtask

   initial begin
      logic [23:0] pw;
      logic [23:0] span;
      logic [15:0] ea;
      logic [15:0] exp;
      logic        hi;
      logic        bm;
      {reset, reg_write, reg_read, table_valid, remap_valid, fetch_load, fetch_step} = 7'h40;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      table_req = '0;
      remap_addr = 16'h0000;
      fetch_target = 24'h000000;
      cur_page = PAGE_RESET;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      reg_rd(REG_TABLE_PAGE, 16'h0000);
      reg_rd(REG_STATUS, 16'h0000);
      reg_wr(8'hFC, 16'h00FF);
      reg_rd(8'hFC, 16'h0000);
      for (int p = 0; p < 2; p++) begin
         cur_page = (p == 0) ? 8'h12 : 8'h92;
         reg_wr(REG_TABLE_PAGE, {8'h00, cur_page});
         reg_rd(REG_TABLE_PAGE, {8'h00, cur_page});
         for (int i = 0; i < 8; i++) begin
            hi = i[2];
            bm = i[1];
            ea = 16'h3456 | 16'(i[0]);
            pw = {cur_page, ea} ^ 24'hA5C33C;
            if (hi) exp = {8'h00, (bm && ea[0]) ? 8'h00 : pw[23:16]};
            else if (bm) exp = {8'h00, ea[0] ? pw[15:8] : pw[7:0]};
            else exp = pw[15:0];
            tbl(hi ? TBL_READ_HIGH : TBL_READ_LOW, bm, ea, 16'h0000, exp);
         end
      end
      // Write latches: word, byte and phantom-byte writes, then read back
      cur_page = LATCH_PAGE;
      reg_wr(REG_TABLE_PAGE, {8'h00, LATCH_PAGE});
      tbl(TBL_WRITE_LOW, 1'b0, 16'h0004, 16'hBEEF, 16'h0000);
      tbl(TBL_WRITE_HIGH, 1'b0, 16'h0004, 16'h0077, 16'h0000);
      tbl(TBL_WRITE_LOW, 1'b1, 16'h0005, 16'h0011, 16'h0000);
      tbl(TBL_WRITE_HIGH, 1'b1, 16'h0005, 16'h00AA, 16'h0000);
      tbl(TBL_READ_LOW, 1'b0, 16'h0004, 16'h0000, 16'h11EF);
      tbl(TBL_READ_HIGH, 1'b0, 16'h0004, 16'h0000, 16'h0077);
      reg_rd(REG_STATUS, 16'h0000);
      // A write outside the latch page is dropped and flagged
      cur_page = 8'h12;
      reg_wr(REG_TABLE_PAGE, 16'h0012);
      tbl(TBL_WRITE_LOW, 1'b0, 16'h0004, 16'h1234, 16'h0000);
      reg_rd(REG_STATUS, 16'h0002);
      reg_wr(REG_STATUS, 16'h0002);
      reg_rd(REG_STATUS, 16'h0000);
      // Remapped window
      reg_wr(REG_REMAP_PAGE, 16'h0003);
      @(posedge clock);
      remap_valid <= 1'b1;
      remap_addr <= 16'h1235;
      @(posedge clock);
      remap_valid <= 1'b0;
      #1 chk(flash_addr, 24'h031235);
      pw = 24'h031235 ^ 24'hA5C33C;
      @(posedge clock);
      #1 chk(remap_done, 1'b1);
      chk(remap_rdata, pw[15:0]);
      // Fetch address
      @(posedge clock);
      fetch_load <= 1'b1;
      fetch_target <= 24'hC00101;
      @(posedge clock);
      fetch_load <= 1'b0;
      fetch_step <= 1'b1;
      #1 chk(fetch_addr, 24'h400100);
      @(posedge clock);
      fetch_step <= 1'b0;
      #1 chk(fetch_addr, 24'h400102);
      // Self-programming granularity
      reg_wr(REG_PROG_ADDR_L, 16'h1234);
      reg_wr(REG_PROG_ADDR_H, 16'h0001);
      for (int k = 0; k < 3; k++) begin
         span = (k == 0) ? DOUBLE_SPAN : (k == 1) ? ROW_SPAN : ERASE_SPAN;
         reg_wr(REG_PROG_CMD, 16'(k));
         #1 chk(prog_valid, 1'b1);
         chk(prog_cmd, {2'(k), 24'h011234 & ~(span - 24'h1), span[10:1]});
      end
      // Kind code 3 names no operation and must start nothing
      reg_wr(REG_PROG_CMD, 16'h0003);
      #1 chk(prog_valid, 1'b0);
      summarize();
   end

   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      summarize();
   end
endmodule // tb
`default_nettype wire
